// >>> lcim_map.svh
// Address map, field positions, reset values and timing counts of the block
`ifndef LCIM_MAP_SVH
`define LCIM_MAP_SVH

// Data-space layout
`define LCIM_IO_BASE        16'h0020
`define LCIM_IO_LAST        16'h005F
`define LCIM_EXT_BASE       16'h0060
`define LCIM_EXT_LAST       16'h00FF
`define LCIM_IO_WIDTH       6

// Sub-ranges inside the extended window
`define LCIM_PCHG_FIRST     16'h006B
`define LCIM_PCHG_LAST      16'h006C
`define LCIM_T2FLAG_FIRST   16'h007C
`define LCIM_T2FLAG_LAST    16'h007D
`define LCIM_T2_FIRST       16'h0080
`define LCIM_T2_LAST        16'h008B

// Baud high-byte registers, fixed I/O numbers
`define LCIM_BAUD0_IO       6'h20
`define LCIM_BAUD1_IO       6'h3C

// Register bus offsets
`define LCIM_ADDR_W         12
`define LCIM_OFF_STATUS     12'h000
`define LCIM_OFF_CTRL       12'h004
`define LCIM_OFF_HITS       12'h008

// Field positions
`define LCIM_ST_COMPAT      0
`define LCIM_ST_LOCKED      1
`define LCIM_ST_FUSE        2
`define LCIM_CT_CNTEN       0
`define LCIM_CT_CLR         1

// Reset values and timing
`define LCIM_CTRL_RST       1'b1
`define LCIM_SETTLE_CYC     3'h4
`define LCIM_RESP_OKAY      2'h0
`define LCIM_RESP_SLVERR    2'h2

`endif

// >>> lcim_pkg.sv
// Types shared by the compatibility map block
`default_nettype none
`include "lcim_map.svh"
package lcim_pkg;

    // Fuse capture sequence, Gray-coded along its path
    typedef enum logic [1:0] {
        LCIM_WAIT   = 2'b00,
        LCIM_SETTLE = 2'b01,
        LCIM_LOCKED = 2'b11
    } lcim_state_t;

    // Where an access lands
    typedef enum logic [2:0] {
        LCIM_TGT_NONE = 3'h0,
        LCIM_TGT_REGF = 3'h1,
        LCIM_TGT_IO   = 3'h2,
        LCIM_TGT_EXT  = 3'h3,
        LCIM_TGT_RAM  = 3'h4
    } lcim_target_t;

    // Access request from the load/store path
    typedef struct packed {
        logic        valid;
        logic        dataSpace;   // 1: load/store, 0: port-style
        logic        write;
        logic [15:0] addr;
    } lcim_req_t;

    // Registered decode answer
    typedef struct packed {
        logic                          valid;
        logic                          write;
        lcim_target_t                  target;
        logic [`LCIM_IO_WIDTH-1:0]     ioNum;
        logic [15:0]                   addr;
        logic                          baudHighCh0;
        logic                          baudHighCh1;
        logic                          secondTimerSel;
        logic                          pinChangeSel;
    } lcim_dec_t;

    // Feature gates
    typedef struct packed {
        logic extVectors;
        logic wdtTimedSeq;
        logic rxDoubleBuf;
        logic pinChange;
        logic secondTimer;
    } lcim_feat_t;

endpackage : lcim_pkg
`default_nettype wire

// >>> lcim_sync3.sv
// Three-stage synchroniser with agreement on the last two stages
`timescale 1ns/1ns
`default_nettype none
module lcim_sync3
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Asynchronous level in, agreed level out
    input  wire logic asyncIn,
    output var  logic syncOut
);
    import lcim_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic agreed;
    } lcim_sync_t;

    lcim_sync_t sync_reg;
    lcim_sync_t sync_next;

    // Stage one only feeds stage two; the agreed value moves
    // only when stages two and three match
    always_comb
    begin
        sync_next    = sync_reg;
        sync_next.s1 = asyncIn;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        if (sync_reg.s2 == sync_reg.s3)
        begin
            sync_next.agreed = sync_reg.s3;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sync_reg <= '0;
        end
        else
        begin
            sync_reg <= sync_next;
        end
    end

    assign syncOut = sync_reg.agreed;

endmodule : lcim_sync3
`default_nettype wire

// >>> lcim_axil_slave.sv
// AXI4-Lite slave front end turning transfers into register strobes
`timescale 1ns/1ns
`default_nettype none
module lcim_axil_slave
#(
    parameter int AW = `LCIM_ADDR_W
)
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst,
    // Write address and data
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output var  logic          s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output var  logic          s_axi_wready,
    // Write response
    output var  logic [1:0]    s_axi_bresp,
    output var  logic          s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // Read address and data
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output var  logic          s_axi_arready,
    output var  logic [31:0]   s_axi_rdata,
    output var  logic [1:0]    s_axi_rresp,
    output var  logic          s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // Register side
    output var  logic          wrEn,
    output var  logic [AW-1:0] wrAddr,
    output var  logic [31:0]   wrData,
    output var  logic [3:0]    wrStrb,
    input  wire logic          wrErr,
    output var  logic          rdEn,
    output var  logic [AW-1:0] rdAddr,
    input  wire logic [31:0]   rdData,
    input  wire logic          rdErr
);
    import lcim_pkg::*;

    typedef struct packed {
        logic          awHeld;
        logic          wHeld;
        logic [AW-1:0] awAddr;
        logic [31:0]   wData;
        logic [3:0]    wStrb;
        logic          bValid;
        logic [1:0]    bResp;
        logic          rValid;
        logic [31:0]   rData;
        logic [1:0]    rResp;
    } lcim_axs_t;

    lcim_axs_t s_reg;
    lcim_axs_t s_next;

    // Handshakes: each channel held once, released by the answer
    assign s_axi_awready = !s_reg.awHeld;
    assign s_axi_wready  = !s_reg.wHeld;
    assign s_axi_arready = !s_reg.rValid;
    assign wrEn   = s_reg.awHeld && s_reg.wHeld && !s_reg.bValid;
    assign wrAddr = s_reg.awAddr;
    assign wrData = s_reg.wData;
    assign wrStrb = s_reg.wStrb;
    assign rdEn   = s_axi_arvalid && !s_reg.rValid;
    assign rdAddr = s_axi_araddr;

    // Capture address and data in either order, answer after both
    always_comb
    begin
        s_next = s_reg;
        if (s_axi_awvalid && !s_reg.awHeld)
        begin
            s_next.awHeld = 1'b1;
            s_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.wHeld)
        begin
            s_next.wHeld = 1'b1;
            s_next.wData = s_axi_wdata;
            s_next.wStrb = s_axi_wstrb;
        end
        if (wrEn)
        begin
            s_next.bValid = 1'b1;
            s_next.bResp  = wrErr ? `LCIM_RESP_SLVERR : `LCIM_RESP_OKAY;
        end
        if (s_reg.bValid && s_axi_bready)
        begin
            s_next.bValid = 1'b0;
            s_next.awHeld = 1'b0;
            s_next.wHeld  = 1'b0;
        end
        if (rdEn)
        begin
            s_next.rValid = 1'b1;
            s_next.rData  = rdData;
            s_next.rResp  = rdErr ? `LCIM_RESP_SLVERR : `LCIM_RESP_OKAY;
        end
        else if (s_reg.rValid && s_axi_rready)
        begin
            s_next.rValid = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign s_axi_bvalid = s_reg.bValid;
    assign s_axi_bresp  = s_reg.bResp;
    assign s_axi_rvalid = s_reg.rValid;
    assign s_axi_rdata  = s_reg.rData;
    assign s_axi_rresp  = s_reg.rResp;

endmodule : lcim_axil_slave
`default_nettype wire

// >>> lcim_compat_map.sv
// Compatibility-fuse address decode and feature gating, top level
// Behaviour
// - Legacy I/O registers keep their addresses in the 64-location I/O space.
// - Data addresses 0x60 to 0xFF decode to extended I/O registers.
// - Extended I/O is reached by load/store only, never by port-style access.
// - Compatibility mode only when the fuse is programmed, else full features.
// - In compatibility mode the extended window decodes as plain RAM.
// - In compatibility mode extended interrupt vectors are removed.
// - In compatibility mode the watchdog timed change sequence is off.
// - In compatibility mode serial receive double buffering is off.
// - In compatibility mode pin-change interrupts are not provided.
// - In compatibility mode the second wide timer is not accessible.
// - Both baud high-byte registers keep fixed addresses in either mode.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module lcim_compat_map
#(
    parameter int AW = `LCIM_ADDR_W
)
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rst,
    // Fuse strap, high when programmed
    input  wire logic                legacyCompatFuse,
    // Load/store path request and decode answer
    input  wire lcim_pkg::lcim_req_t req,
    output var  lcim_pkg::lcim_dec_t dec,
    output var  logic                mapReady,
    // Feature gates
    output var  lcim_pkg::lcim_feat_t feat,
    // AXI4-Lite write channels
    input  wire logic [AW-1:0]       s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output var  logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output var  logic                s_axi_wready,
    output var  logic [1:0]          s_axi_bresp,
    output var  logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [AW-1:0]       s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output var  logic                s_axi_arready,
    output var  logic [31:0]         s_axi_rdata,
    output var  logic [1:0]          s_axi_rresp,
    output var  logic                s_axi_rvalid,
    input  wire logic                s_axi_rready
);
    import lcim_pkg::*;

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        lcim_state_t st;
        logic [2:0]  settleCnt;
        logic        compat;
        logic        locked;
        lcim_feat_t  feat;
        lcim_dec_t   dec;
        logic [15:0] hits;
        logic        cntEn;
    } lcim_top_t;

    lcim_top_t t_reg;
    lcim_top_t t_next;

    logic            fuseAgreed;
    logic            wrEn;
    logic [AW-1:0]   wrAddr;
    logic [31:0]     wrData;
    logic [3:0]      wrStrb;
    logic            wrErr;
    logic            rdEn;
    logic [AW-1:0]   rdAddr;
    logic [31:0]     rdData;
    logic            rdErr;
    logic            inIo;
    logic            inExt;
    lcim_dec_t       d;

    // ********************************************************
    // Fuse synchroniser and bus front end
    // ********************************************************
    lcim_sync3 u_fuse_sync
    (
        .mclk    (mclk),
        .rst     (rst),
        .asyncIn (legacyCompatFuse),
        .syncOut (fuseAgreed)
    );

    lcim_axil_slave #(.AW(AW)) u_bus
    (
        .mclk          (mclk),
        .rst           (rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wrEn          (wrEn),
        .wrAddr        (wrAddr),
        .wrData        (wrData),
        .wrStrb        (wrStrb),
        .wrErr         (wrErr),
        .rdEn          (rdEn),
        .rdAddr        (rdAddr),
        .rdData        (rdData),
        .rdErr         (rdErr)
    );

    // ********************************************************
    // Address decode
    // ********************************************************
    // Window tests on the data-space address
    assign inIo  = req.addr >= `LCIM_IO_BASE && req.addr <= `LCIM_IO_LAST;
    assign inExt = req.addr >= `LCIM_EXT_BASE && req.addr <= `LCIM_EXT_LAST;

    // Requests before the fuse is locked land nowhere, so no access
    // can see a half-settled map
    always_comb
    begin
        d        = '0;
        d.valid  = req.valid;
        d.write  = req.write;
        d.addr   = req.addr;
        d.target = LCIM_TGT_NONE;
        if (!req.valid || !t_reg.locked)
        begin
            d.target = LCIM_TGT_NONE;
        end
        else if (!req.dataSpace)
        begin
            // Port-style access sees only the 64 I/O slots
            d.target = LCIM_TGT_IO;
            d.ioNum  = req.addr[`LCIM_IO_WIDTH-1:0];
        end
        else if (req.addr < `LCIM_IO_BASE)
        begin
            d.target = LCIM_TGT_REGF;
        end
        else if (inIo)
        begin
            d.target = LCIM_TGT_IO;
            d.ioNum  = 6'(req.addr - `LCIM_IO_BASE);
        end
        else if (inExt && !t_reg.compat)
        begin
            d.target = LCIM_TGT_EXT;
            d.pinChangeSel = req.addr >= `LCIM_PCHG_FIRST &&
                             req.addr <= `LCIM_PCHG_LAST;
            d.secondTimerSel = (req.addr >= `LCIM_T2_FIRST &&
                                req.addr <= `LCIM_T2_LAST) ||
                               (req.addr >= `LCIM_T2FLAG_FIRST &&
                                req.addr <= `LCIM_T2FLAG_LAST);
        end
        else
        begin
            // Compatibility mode puts RAM back over the window
            d.target = LCIM_TGT_RAM;
        end
        // Baud high bytes sit at fixed I/O numbers in both modes
        d.baudHighCh0 = d.target == LCIM_TGT_IO &&
                        d.ioNum == `LCIM_BAUD0_IO;
        d.baudHighCh1 = d.target == LCIM_TGT_IO &&
                        d.ioNum == `LCIM_BAUD1_IO;
    end

    // ********************************************************
    // Fuse capture, gating, counters and registers
    // ********************************************************
    always_comb
    begin
        t_next     = t_reg;
        t_next.dec = d;
        case (t_reg.st)
            LCIM_WAIT:
            begin
                t_next.settleCnt = '0;
                t_next.st        = LCIM_SETTLE;
            end
            LCIM_SETTLE:
            begin
                // Let the synchroniser refill after reset before trusting it
                t_next.settleCnt = t_reg.settleCnt + 3'h1;
                if (t_reg.settleCnt == `LCIM_SETTLE_CYC)
                begin
                    t_next.compat = fuseAgreed;
                    t_next.locked = 1'b1;
                    t_next.st     = LCIM_LOCKED;
                    t_next.feat.extVectors  = !fuseAgreed;
                    t_next.feat.wdtTimedSeq = !fuseAgreed;
                    t_next.feat.rxDoubleBuf = !fuseAgreed;
                    t_next.feat.pinChange   = !fuseAgreed;
                    t_next.feat.secondTimer = !fuseAgreed;
                end
            end
            LCIM_LOCKED:
            begin
                // Nothing leaves this state but reset
                t_next.st = LCIM_LOCKED;
            end
            default:
            begin
                t_next.st = LCIM_WAIT;
            end
        endcase
        // Count window accesses; clear from software wins only if idle
        if (wrEn && wrAddr == `LCIM_OFF_CTRL && wrStrb[0])
        begin
            t_next.cntEn = wrData[`LCIM_CT_CNTEN];
            if (wrData[`LCIM_CT_CLR])
            begin
                t_next.hits = '0;
            end
        end
        if (t_reg.cntEn && req.valid && req.dataSpace && inExt &&
            t_reg.locked)
        begin
            t_next.hits = t_reg.hits + 16'h0001;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            t_reg       <= '0;
            t_reg.st    <= LCIM_WAIT;
            t_reg.cntEn <= `LCIM_CTRL_RST;
        end
        else
        begin
            t_reg <= t_next;
        end
    end

    // Register read mux; unmapped offsets answer SLVERR with zero
    always_comb
    begin
        rdData = '0;
        rdErr  = 1'b0;
        if (rdAddr == `LCIM_OFF_STATUS)
        begin
            rdData[`LCIM_ST_COMPAT] = t_reg.compat;
            rdData[`LCIM_ST_LOCKED] = t_reg.locked;
            rdData[`LCIM_ST_FUSE]   = fuseAgreed;
        end
        else if (rdAddr == `LCIM_OFF_CTRL)
        begin
            rdData[`LCIM_CT_CNTEN] = t_reg.cntEn;
        end
        else if (rdAddr == `LCIM_OFF_HITS)
        begin
            rdData[15:0] = t_reg.hits;
        end
        else
        begin
            rdErr = 1'b1;
        end
    end

    // Only the control word takes writes
    assign wrErr    = wrAddr != `LCIM_OFF_CTRL;
    assign dec      = t_reg.dec;
    assign feat     = t_reg.feat;
    assign mapReady = t_reg.locked;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    port_io_a: assert property (
        req.valid && !req.dataSpace && mapReady |=>
        dec.target == LCIM_TGT_IO && dec.ioNum == $past(req.addr[5:0]))
        else $error("port access lost its I/O slot");

    data_io_a: assert property (
        req.valid && req.dataSpace && inIo && mapReady |=>
        dec.target == LCIM_TGT_IO &&
        dec.ioNum == 6'($past(req.addr) - 16'h0020))
        else $error("data access to I/O slot misplaced");

    ext_win_a: assert property (
        req.valid && req.dataSpace && inExt && mapReady && !t_reg.compat
        |=> dec.target == LCIM_TGT_EXT)
        else $error("extended window not decoded");

    port_no_ext_a: assert property (
        $past(req.valid && !req.dataSpace) |-> dec.target != LCIM_TGT_EXT)
        else $error("port access reached extended window");

    fuse_mode_a: assert property (
        $rose(t_reg.locked) |-> t_reg.compat == $past(fuseAgreed))
        else $error("mode differs from fuse");

    ram_win_a: assert property (
        req.valid && req.dataSpace && inExt && mapReady && t_reg.compat
        |=> dec.target == LCIM_TGT_RAM && !dec.secondTimerSel)
        else $error("compat window not RAM");

    vec_gate_a: assert property (
        mapReady |-> feat.extVectors == !t_reg.compat)
        else $error("vector gate wrong");

    wdt_gate_a: assert property (
        t_reg.compat |-> !feat.wdtTimedSeq)
        else $error("watchdog sequence on in compat mode");

    rx_gate_a: assert property (
        mapReady |-> feat.rxDoubleBuf == !t_reg.compat)
        else $error("receive buffering gate wrong");

    pchg_gate_a: assert property (
        t_reg.compat |-> !feat.pinChange && !dec.pinChangeSel)
        else $error("pin change present in compat mode");

    timer_gate_a: assert property (
        t_reg.compat |=> !feat.secondTimer && !dec.secondTimerSel)
        else $error("second timer reachable in compat mode");

    baud_fix_a: assert property (
        req.valid && !req.dataSpace && mapReady &&
        req.addr[5:0] == 6'h20 |=> dec.baudHighCh0 && !dec.baudHighCh1)
        else $error("baud high select wrong");

    mode_hold_a: assert property (
        mapReady |=> mapReady && $stable(t_reg.compat) && $stable(feat))
        else $error("mode changed before reset");

endmodule : lcim_compat_map
`default_nettype wire

// >>> lcim_cpu_model.sv
// Load/store path model that drives decode requests into the map
`timescale 1ns/1ns
`default_nettype none
module lcim_cpu_model
(
    // Clock
    input  wire logic                mclk,
    // Request towards the map
    output var  lcim_pkg::lcim_req_t req
);
    import lcim_pkg::*;

    initial req = '0;

    // One request a cycle, changed just after the edge
    task automatic issue(input logic [16:0] e);
        @(posedge mclk);
        req <= '{1'b1, e[16], e[0], e[15:0]};
    endtask : issue

    // A released bus shows the inverse, never the last address
    task automatic idle();
        @(posedge mclk);
        req <= '{1'b0, ~req.dataSpace, 1'b0, ~req.addr};
    endtask : idle
endmodule : lcim_cpu_model
`default_nettype wire

// >>> lcim_compat_map_tb.sv
// Self-checking bench of the compatibility map
`timescale 1ns/1ns
`default_nettype none
module lcim_compat_map_tb;
    import lcim_pkg::*;

    logic        mclk = 1'b0, rst = 1'b1, fuse = 1'b0, mapReady;
    lcim_req_t   req;
    lcim_dec_t   dec;
    lcim_feat_t  feat;
    logic [11:0] awAddr = '0, arAddr = '0;
    logic [31:0] wData = '0, rData;
    logic [1:0]  bResp, rResp;
    logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0;
    logic        rReady = 0, awReady, wReady, bValid, arReady, rValid;
    int          nFail = 0;
    int          samplesChecked = 0;
    // Data and port accesses; bit 16 set means load/store
    localparam logic [16:0] TBL [13] = '{17'h10010, 17'h10040,
        17'h1005C, 17'h10060, 17'h1006B, 17'h1006C, 17'h1007C,
        17'h10080, 17'h1008B, 17'h100FF, 17'h10100, 17'h00020,
        17'h00080};

    always #10 mclk = ~mclk;

    lcim_compat_map #(.AW(12)) lcim_compat_map_inst (.mclk(mclk),
        .rst(rst), .legacyCompatFuse(fuse), .req(req), .dec(dec),
        .mapReady(mapReady), .feat(feat), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady));
    lcim_cpu_model lcim_cpu_model_inst (.mclk(mclk), .req(req));

    task automatic check_val(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
        samplesChecked++;
        if (got !== exp)
        begin
            nFail++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check_val

    // Write and read hold each channel until its own handshake edge
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        @(posedge mclk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        // Only the watchdog ends a wait that never gets its answer
        forever
        begin
            @(posedge mclk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid)
            begin
                r = bResp;
                bReady <= 1'b0;
                break;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge mclk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid)
            begin
                d = rData;
                r = rResp;
                rReady <= 1'b0;
                break;
            end
        end
    endtask : axi_rd

    // Expected decode worked out from the address map
    task automatic check_dec(input logic [16:0] e, input logic cm);
        logic [15:0] a;
        logic [2:0]  t;
        logic [5:0]  io;
        logic        tm, pc;
        a = e[15:0];
        io = 6'h00;
        tm = !cm && e[16] && (a inside {[16'h007C:16'h007D],
                                        [16'h0080:16'h008B]});
        pc = !cm && e[16] && (a inside {[16'h006B:16'h006C]});
        t = 3'h4;
        if (!e[16]) {t, io} = {3'h2, a[5:0]};
        else if (a < 16'h0020) t = 3'h1;
        else if (a < 16'h0060) {t, io} = {3'h2, a[5:0] - 6'h20};
        else if (a < 16'h0100) t = cm ? 3'h4 : 3'h3;
        check_val("decode", {1'b1, e[0], t, io, io == 6'h20, io == 6'h3C,
            tm, pc}, {dec.valid, dec.write, dec.target,
            (dec.target === LCIM_TGT_IO) ? dec.ioNum : 6'h00,
            dec.baudHighCh0, dec.baudHighCh1, dec.secondTimerSel,
            dec.pinChangeSel});
        check_val("dec addr", {16'h0000, a}, dec.addr);
    endtask : check_dec

    task automatic run_mode(input logic cm);
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge mclk);
        fuse <= cm;
        rst <= 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 20 && mapReady !== 1'b1; i++) @(posedge mclk);
        #1;
        check_val("map ready", 32'h1, mapReady);
        check_val("gates", cm ? 32'h0 : 32'h1F, feat);
        axi_rd(12'h000, d, r);
        check_val("status", {cm, 1'b1, cm}, d);
        axi_rd(12'h004, d, r);
        check_val("ctrl reset", 32'h1, d);
        axi_wr(12'h004, 32'h3, r);
        check_val("ctrl resp", 32'h0, r);
        axi_wr(12'h008, 32'h0, r);
        check_val("ro resp", 32'h2, r);
        axi_rd(12'h00C, d, r);
        check_val("unmapped data", 32'h0, d);
        check_val("unmapped resp", 32'h2, r);
        // Back to back so the decode never gets an idle cycle to hide in
        for (int i = 0; i <= 13; i++)
        begin
            if (i < 13) lcim_cpu_model_inst.issue(TBL[i]);
            else lcim_cpu_model_inst.idle();
            #1;
            if (i > 0) check_dec(TBL[i - 1], cm);
        end
        axi_rd(12'h008, d, r);
        check_val("hits", 32'h7, d);
        fuse <= ~cm;
        repeat (10) @(posedge mclk);
        #1;
        check_val("held gates", cm ? 32'h0 : 32'h1F, feat);
    endtask : run_mode

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        run_mode(1'b0);
        $display("full feature test done");
        run_mode(1'b1);
        $display("compatibility test done");
        tally_and_finish();
    end

    // Both runs together take under two hundred cycles
    initial
    begin
        repeat (3000) @(posedge mclk);
        nFail++;
        tally_and_finish();
    end
endmodule : lcim_compat_map_tb
`default_nettype wire
